/* hw/crs_map.svh */
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH
// reset vector location (high byte at the lower address)
`define CRS_RST_VEC_HI    16'hFFFE
`define CRS_RST_VEC_LO    16'hFFFF
// software trap vector location
`define CRS_SWI_VEC       16'hFFFC
// reset entry sequence cycle count and queue prefetch byte count
`define CRS_RST_SEQ_CYC   6
`define CRS_PREFETCH_N    3
// condition code mask bit position
`define CRS_CCR_MASK_BIT  3
// stack pointer reset value and direct page high byte
`define CRS_SP_RST        16'h00FF
`define CRS_DPAGE_HI      8'h00
`endif

/* hw/crs_pkg.sv */
package crs_pkg;
	typedef enum logic [1:0] {
		CRS_AM_REL = 2'b00,
		CRS_AM_IMM = 2'b01,
		CRS_AM_DIR = 2'b10,
		CRS_AM_SP2 = 2'b11
	} crs_amode_t;

	typedef enum logic [3:0] {
		CRS_ST_RESET  = 4'b0000,
		CRS_ST_RVEC_H = 4'b0001,
		CRS_ST_RVEC_L = 4'b0010,
		CRS_ST_RIDLE  = 4'b0011,
		CRS_ST_RUN    = 4'b0100,
		CRS_ST_PUSH   = 4'b0101,
		CRS_ST_IVEC_H = 4'b0110,
		CRS_ST_IVEC_L = 4'b0111,
		CRS_ST_IIDLE  = 4'b1000,
		CRS_ST_FILL   = 4'b1001
	} crs_state_t;

	// memory bus request
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} crs_bus_t;

	// cpu context stacked on interrupt entry
	typedef struct packed {
		logic [15:0] pc;
		logic [7:0]  x;
		logic [7:0]  a;
		logic [7:0]  condition_code_register;
	} crs_ctx_t;
endpackage : crs_pkg

/* hw/crs_rst_sync.sv */
`timescale 1ns/10ps
// merges reset sources; pin is active low and asynchronous, so it is synchronised
module crs_rst_sync (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic por_in,
	input  wire logic wdog_rst_in,
	input  wire logic ext_rst_n_in,
	input  wire logic src_done_in,
	output logic      abort_out,
	output logic      concluded_out
);
	logic pin_s1_q, pin_s1_d;
	logic pin_s2_q, pin_s2_d;

	always_comb begin
		pin_s1_d = ext_rst_n_in;
		pin_s2_d = pin_s1_q;
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
		end else begin
			pin_s1_q <= pin_s1_d;
			pin_s2_q <= pin_s2_d;
		end
	end

	// rst_in, power-on and watchdog abort at once; the pin aborts two cycles after it goes low
	assign abort_out = rst_in | por_in | wdog_rst_in | ~pin_s2_q;
	// finished only when source check done and pin released
	assign concluded_out = src_done_in & pin_s2_q;
endmodule : crs_rst_sync

/* hw/crs_agu.sv */
`timescale 1ns/10ps
// operand effective address generator
module crs_agu (
	input  wire logic               ref_clk_in,
	input  wire logic               rst_in,
	input  wire crs_pkg::crs_amode_t mode_in,
	input  wire logic [15:0]        pc_in,
	input  wire logic [15:0]        sp_in,
	input  wire logic [7:0]         byte1_in,
	input  wire logic [7:0]         byte2_in,
	input  wire logic               take_in,
	output logic [15:0]             ea_out
);
	`include "crs_map.svh"
	logic [15:0] ea_q, ea_d;

	always_comb begin
		case (mode_in)
			crs_pkg::CRS_AM_REL: begin
				// relative target; untaken branch leaves pc
				ea_d = take_in ? pc_in + {{8{byte1_in[7]}}, byte1_in} : pc_in;
			end
			crs_pkg::CRS_AM_IMM: ea_d = {byte1_in, byte2_in};
			crs_pkg::CRS_AM_DIR: ea_d = {`CRS_DPAGE_HI, byte1_in};
			crs_pkg::CRS_AM_SP2: ea_d = sp_in + {byte1_in, byte2_in};
			default:             ea_d = pc_in;
		endcase
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) ea_q <= 16'h0000;
		else ea_q <= ea_d;
	end
	assign ea_out = ea_q;

	a_dir_page_zero: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		mode_in == crs_pkg::CRS_AM_DIR |=> ea_out[15:8] == 8'h00)
		else $error("direct address left page zero");
	a_imm_byte_order: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		mode_in == crs_pkg::CRS_AM_IMM |=> ea_out == {$past(byte1_in), $past(byte2_in)})
		else $error("inline operand byte order wrong");
	a_rel_sign_ext: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(mode_in == crs_pkg::CRS_AM_REL && take_in && byte1_in[7])
		|=> ea_out == $past(pc_in) - (16'h0100 - {8'h00, $past(byte1_in)}))
		else $error("negative branch offset not sign extended");
	a_sp2_sum: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		mode_in == crs_pkg::CRS_AM_SP2 |=> ea_out == $past(sp_in) + {$past(byte1_in), $past(byte2_in)})
		else $error("stack offset address wrong");
endmodule : crs_agu

/* hw/crs_seq.sv */
`timescale 1ns/10ps
//
// Overview of operation
// - branch adds sign-extended 8-bit offset after opcode to pc when taken
// - 16-bit inline operand: high byte first, low byte next
// - zero-page address is zero high byte over instruction byte
// - stack offset mode address is stack pointer plus 16-bit offset
// - reset comes from power-on, watchdog supervisor, or external low pin
// - power-on or watchdog reset aborts the current operation immediately; the pin does so two cycles later
// - reset ends after source check completes and the pin is released
// - after reset, six cycles fetch top-of-memory vector and fill queue
// - interrupt waits for instruction end; saved pc is next instruction
// - entry matches software trap; vector latched from highest pending request
// - push pc low, pc high, index, accumulator, condition codes
// - set interrupt mask after condition codes are stacked
// - read vector high byte then low byte
// - exactly one idle bus cycle after interrupt vector reads, none after reset vector reads
// - fetch three program bytes from vector to fill queue
module crs_seq (
	input  wire logic                ref_clk_in,
	input  wire logic                rst_in,
	input  wire logic                por_in,
	input  wire logic                wdog_rst_in,
	input  wire logic                ext_rst_n_in,
	input  wire logic                src_done_in,
	input  wire logic                irq_req_in,
	input  wire logic [15:0]         irq_vec_in,
	input  wire logic                swi_in,
	input  wire logic                insn_end_in,
	input  wire crs_pkg::crs_ctx_t   ctx_in,
	input  wire logic [7:0]          rdata_in,
	input  wire crs_pkg::crs_amode_t mode_in,
	input  wire logic [7:0]          byte1_in,
	input  wire logic [7:0]          byte2_in,
	input  wire logic                take_in,
	output crs_pkg::crs_bus_t        bus_out,
	output logic [15:0]              pc_out,
	output logic [15:0]              stack_pointer_out,
	output logic [7:0]               condition_code_register_out,
	output logic                     queue_ready_out,
	output logic                     abort_out,
	output logic [15:0]              ea_out
);
	`include "crs_map.svh"

	crs_pkg::crs_state_t st_q, st_d;
	logic [2:0]          cnt_q, cnt_d;
	logic [15:0]         pc_q, pc_d;
	logic [15:0]         sp_q, sp_d;
	logic [15:0]         vec_q, vec_d;
	logic [7:0]          ccr_q, ccr_d;
	crs_pkg::crs_ctx_t   ctx_q, ctx_d;
	crs_pkg::crs_bus_t   bus_q, bus_d;
	logic                rdy_q, rdy_d;
	logic                abort;
	logic                concluded;

	// ========================================
	// reset sources and address generator
	crs_rst_sync u_rst (
		.ref_clk_in    (ref_clk_in),
		.rst_in        (rst_in),
		.por_in        (por_in),
		.wdog_rst_in   (wdog_rst_in),
		.ext_rst_n_in  (ext_rst_n_in),
		.src_done_in   (src_done_in),
		.abort_out     (abort),
		.concluded_out (concluded)
	);

	crs_agu u_agu (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.mode_in    (mode_in),
		.pc_in      (pc_q),
		.sp_in      (sp_q),
		.byte1_in   (byte1_in),
		.byte2_in   (byte2_in),
		.take_in    (take_in),
		.ea_out     (ea_out)
	);

	function automatic crs_pkg::crs_bus_t rd(input logic [15:0] a);
		rd = '{valid: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
	endfunction : rd

	// ========================================
	// sequencer
	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		pc_d  = pc_q;
		sp_d  = sp_q;
		vec_d = vec_q;
		ccr_d = ccr_q;
		ctx_d = ctx_q;
		rdy_d = rdy_q;
		bus_d = '0;
		case (st_q)
			crs_pkg::CRS_ST_RESET: begin
				rdy_d = 1'b0;
				if (concluded) begin
					st_d  = crs_pkg::CRS_ST_RVEC_H;
					bus_d = rd(`CRS_RST_VEC_HI);
				end
			end
			crs_pkg::CRS_ST_RVEC_H: begin
				pc_d[15:8] = rdata_in;
				st_d       = crs_pkg::CRS_ST_RVEC_L;
				bus_d      = rd(`CRS_RST_VEC_LO);
			end
			crs_pkg::CRS_ST_RVEC_L: begin
				pc_d[7:0] = rdata_in;
				vec_d     = {pc_q[15:8], rdata_in};
				// first queue byte is read here, so the fill goes on from the second
				cnt_d     = 3'd1;
				st_d      = crs_pkg::CRS_ST_FILL;
				bus_d     = rd({pc_q[15:8], rdata_in});
			end
			crs_pkg::CRS_ST_RUN: begin
				rdy_d = 1'b1;
				// entry only at an instruction boundary
				if (insn_end_in && (swi_in || (irq_req_in && !ccr_q[`CRS_CCR_MASK_BIT]))) begin
					ctx_d = ctx_in;
					// vector frozen at sequence start
					vec_d = swi_in ? `CRS_SWI_VEC : irq_vec_in;
					cnt_d = 3'd0;
					rdy_d = 1'b0;
					st_d  = crs_pkg::CRS_ST_PUSH;
				end
			end
			crs_pkg::CRS_ST_PUSH: begin
				bus_d.valid = 1'b1;
				bus_d.write = 1'b1;
				bus_d.addr  = sp_q;
				case (cnt_q)
					3'd0:    bus_d.wdata = ctx_q.pc[7:0];
					3'd1:    bus_d.wdata = ctx_q.pc[15:8];
					3'd2:    bus_d.wdata = ctx_q.x;
					3'd3:    bus_d.wdata = ctx_q.a;
					default: bus_d.wdata = ctx_q.condition_code_register;
				endcase
				sp_d  = sp_q - 16'd1;
				cnt_d = cnt_q + 3'd1;
				if (cnt_q == 3'd4) begin
					ccr_d                     = ctx_q.condition_code_register;
					ccr_d[`CRS_CCR_MASK_BIT]  = 1'b1;
					st_d                      = crs_pkg::CRS_ST_IVEC_H;
				end
			end
			crs_pkg::CRS_ST_IVEC_H: begin
				bus_d = rd(vec_q);
				st_d  = crs_pkg::CRS_ST_IVEC_L;
			end
			crs_pkg::CRS_ST_IVEC_L: begin
				pc_d[15:8] = rdata_in;
				bus_d      = rd(vec_q + 16'd1);
				st_d       = crs_pkg::CRS_ST_IIDLE;
			end
			crs_pkg::CRS_ST_IIDLE: begin
				// single free bus cycle
				pc_d[7:0] = rdata_in;
				cnt_d     = 3'd0;
				st_d      = crs_pkg::CRS_ST_FILL;
			end
			crs_pkg::CRS_ST_FILL: begin
				// prefetch queue bytes up to the third: three after an interrupt, the last two after reset
				bus_d = rd(pc_q + {13'd0, cnt_q});
				cnt_d = cnt_q + 3'd1;
				if (cnt_q == 3'(`CRS_PREFETCH_N - 1)) begin
					st_d = crs_pkg::CRS_ST_RUN;
				end
			end
			default: st_d = crs_pkg::CRS_ST_RESET;
		endcase
		// reset never waits for a boundary
		if (abort) begin
			st_d  = crs_pkg::CRS_ST_RESET;
			bus_d = '0;
			rdy_d = 1'b0;
			sp_d  = `CRS_SP_RST;
			ccr_d = 8'h00;
			ccr_d[`CRS_CCR_MASK_BIT] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			st_q  <= crs_pkg::CRS_ST_RESET;
			cnt_q <= 3'd0;
			pc_q  <= 16'h0000;
			sp_q  <= `CRS_SP_RST;
			vec_q <= 16'h0000;
			ccr_q <= 8'h08;
			ctx_q <= '0;
			bus_q <= '0;
			rdy_q <= 1'b0;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
			pc_q  <= pc_d;
			sp_q  <= sp_d;
			vec_q <= vec_d;
			ccr_q <= ccr_d;
			ctx_q <= ctx_d;
			bus_q <= bus_d;
			rdy_q <= rdy_d;
		end
	end

	assign bus_out                     = bus_q;
	assign pc_out                      = pc_q;
	assign stack_pointer_out           = sp_q;
	assign condition_code_register_out = ccr_q;
	assign queue_ready_out             = rdy_q;
	assign abort_out                   = abort;

	// ========================================
	// checks
	a_push_sp_dec: assert property (@(posedge ref_clk_in) disable iff (abort)
		st_q == crs_pkg::CRS_ST_PUSH |=> sp_q == $past(sp_q) - 16'd1)
		else $error("stack pointer not decremented per push");
	a_push_order: assert property (@(posedge ref_clk_in) disable iff (abort)
		(st_q == crs_pkg::CRS_ST_PUSH && cnt_q == 3'd0)
		|=> bus_q.write && bus_q.wdata == ctx_q.pc[7:0]
		##1 bus_q.wdata == ctx_q.pc[15:8] ##1 bus_q.wdata == ctx_q.x
		##1 bus_q.wdata == ctx_q.a ##1 bus_q.wdata == ctx_q.condition_code_register)
		else $error("stack push order wrong");
	a_mask_after_push: assert property (@(posedge ref_clk_in) disable iff (abort)
		(st_q == crs_pkg::CRS_ST_PUSH && cnt_q == 3'd4) |=> ccr_q[3])
		else $error("mask not set after stacking");
	a_vec_hi_lo: assert property (@(posedge ref_clk_in) disable iff (abort)
		st_q == crs_pkg::CRS_ST_IVEC_H |=> bus_q.addr == vec_q
		##1 bus_q.addr == vec_q + 16'd1 ##1 !bus_q.valid ##1 bus_q.valid)
		else $error("vector read order or idle cycle wrong");
	a_fill_three: assert property (@(posedge ref_clk_in) disable iff (abort)
		st_q == crs_pkg::CRS_ST_IIDLE |=> st_q == crs_pkg::CRS_ST_FILL [*3]
		##1 st_q == crs_pkg::CRS_ST_RUN)
		else $error("queue fill not three bytes");
	a_reset_six: assert property (@(posedge ref_clk_in) disable iff (abort)
		(st_q == crs_pkg::CRS_ST_RESET && concluded)
		|=> bus_q.addr == 16'hFFFE ##1 bus_q.addr == 16'hFFFF ##4 queue_ready_out)
		else $error("reset sequence not six cycles");
	a_abort_now: assert property (@(posedge ref_clk_in)
		abort |=> st_q == crs_pkg::CRS_ST_RESET && !bus_q.valid)
		else $error("reset did not abort at once");
	a_boundary: assert property (@(posedge ref_clk_in) disable iff (abort)
		(st_q == crs_pkg::CRS_ST_RUN && !insn_end_in) |=> st_q != crs_pkg::CRS_ST_PUSH)
		else $error("interrupt taken mid instruction");
endmodule : crs_seq

/* sim/crs_mem_model.sv */
`timescale 1ns/10ps
// =============================================
// memory on the far side of the bus
// =============================================
module crs_mem_model (
	input  wire logic              ref_clk_in,
	input  wire crs_pkg::crs_bus_t bus_in,
	output logic [7:0]             rdata_out
);
	function automatic logic [7:0] peek(input logic [15:0] a);
		case (a)
			16'hFFFE: peek = 8'h12;
			16'hFFFF: peek = 8'h34;
			16'hFFFC: peek = 8'h56;
			16'hFFFD: peek = 8'h78;
			default:  peek = a[7:0] ^ a[15:8];
		endcase
	endfunction : peek

	logic [7:0] junk_q;

	initial junk_q = 8'h00;
	// the sequencer latches read data in the cycle the request stands, so data is combinational
	// outside a read the byte keeps changing, so a stale value is never mistaken for data
	always @(posedge ref_clk_in) begin
		junk_q <= ~junk_q;
	end
	assign rdata_out = (bus_in.valid && !bus_in.write) ? peek(bus_in.addr) : junk_q;
endmodule : crs_mem_model

/* sim/tb_cpu_reset_irq_sequencer_agu.sv */
`timescale 1ns/10ps
module tb_cpu_reset_irq_sequencer_agu;
	logic                ref_clk_in = 1'b0;
	logic                rst_in = 1'b1;
	logic                por_in = 1'b0;
	logic                wdog_rst_in = 1'b0;
	logic                ext_rst_n_in = 1'b1;
	logic                src_done_in = 1'b0;
	logic                irq_req_in = 1'b0;
	logic                swi_in = 1'b0;
	logic                insn_end_in = 1'b0;
	logic                take_in = 1'b0;
	logic [15:0]         irq_vec_in = 16'hFFFA;
	crs_pkg::crs_ctx_t   ctx_in = '0;
	crs_pkg::crs_amode_t mode_in = crs_pkg::CRS_AM_REL;
	logic [7:0]          byte1_in = 8'h00;
	logic [7:0]          byte2_in = 8'h00;
	logic [7:0]          rdata_in;
	crs_pkg::crs_bus_t   bus_out;
	logic [15:0]         pc_out;
	logic [15:0]         stack_pointer_out;
	logic [15:0]         ea_out;
	logic [7:0]          condition_code_register_out;
	logic                queue_ready_out;
	logic                abort_out;
	int                  fail_count = 0;
	int                  comparisons = 0;
	int                  cycles = 0;
	logic [25:0]         seen [0:10];

	crs_seq u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .por_in(por_in),
		.wdog_rst_in(wdog_rst_in), .ext_rst_n_in(ext_rst_n_in), .src_done_in(src_done_in),
		.irq_req_in(irq_req_in), .irq_vec_in(irq_vec_in), .swi_in(swi_in),
		.insn_end_in(insn_end_in), .ctx_in(ctx_in), .rdata_in(rdata_in), .mode_in(mode_in),
		.byte1_in(byte1_in), .byte2_in(byte2_in), .take_in(take_in), .bus_out(bus_out),
		.pc_out(pc_out), .stack_pointer_out(stack_pointer_out),
		.condition_code_register_out(condition_code_register_out),
		.queue_ready_out(queue_ready_out), .abort_out(abort_out), .ea_out(ea_out));
	crs_mem_model u_mem (.ref_clk_in(ref_clk_in), .bus_in(bus_out), .rdata_out(rdata_in));

	always #5 ref_clk_in = ~ref_clk_in;

	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [25:0] got, input logic [25:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : step

	function automatic logic [25:0] rd(input logic [15:0] a);
		return {2'b10, a, 8'h00};
	endfunction : rd

	// waits for the first access, then records n cycles; idle slots read as zero
	task automatic grab(input int n);
		int k;
		k = 0;
		while (bus_out.valid !== 1'b1 && k < 40) begin
			step(1);
			k++;
		end
		for (int i = 0; i < n; i++) begin
			seen[i] = !bus_out.valid ? '0 : bus_out.write ? bus_out : {bus_out[25:8], 8'h00};
			step(1);
		end
	endtask : grab

	task automatic t_reset_walk();
		step(10);
		chk("bus before release", {25'h0, bus_out.valid}, 26'h0);
		src_done_in = 1'b1;
		grab(5);
		chk("vector high", seen[0], rd(16'hFFFE));
		chk("vector low", seen[1], rd(16'hFFFF));
		for (int i = 0; i < 3; i++) begin
			chk("reset fill", seen[2 + i], rd(16'(16'h1234 + i)));
		end
		chk("ready", {25'h0, queue_ready_out}, 26'h1);
		$display("test reset_walk done");
	endtask : t_reset_walk

	task automatic fire_trap();
		ctx_in = '{pc: 16'h2000, x: 8'h11, a: 8'h22, condition_code_register: 8'h00};
		step(2);
		swi_in = 1'b1;
		insn_end_in = 1'b1;
		step(1);
		swi_in = 1'b0;
		insn_end_in = 1'b0;
	endtask : fire_trap

	task automatic t_trap_entry();
		logic [7:0] pushed [0:4];
		pushed = '{8'h00, 8'h20, 8'h11, 8'h22, 8'h00};
		fire_trap();
		grab(11);
		for (int i = 0; i < 5; i++) begin
			chk("push", seen[i], {2'b11, 16'(16'h00FF - i), pushed[i]});
		end
		chk("trap vector high", seen[5], rd(16'hFFFC));
		chk("trap vector low", seen[6], rd(16'hFFFD));
		chk("free cycle", seen[7], 26'h0);
		for (int i = 0; i < 3; i++) begin
			chk("handler fill", seen[8 + i], rd(16'(16'h5678 + i)));
		end
		chk("ready", {25'h0, queue_ready_out}, 26'h1);
		chk("stack pointer", {10'h0, stack_pointer_out}, 26'h00FA);
		chk("mask", {25'h0, condition_code_register_out[3]}, 26'h1);
		$display("test trap_entry done");
	endtask : t_trap_entry

	task automatic t_irq_masked();
		irq_req_in = 1'b1;
		insn_end_in = 1'b1;
		step(1);
		insn_end_in = 1'b0;
		for (int i = 0; i < 6; i++) begin
			chk("masked bus", {25'h0, bus_out.valid}, 26'h0);
			step(1);
		end
		irq_req_in = 1'b0;
		$display("test irq_masked done");
	endtask : t_irq_masked

	task automatic agu(input crs_pkg::crs_amode_t m, input logic [7:0] b1, input logic [7:0] b2,
		input logic [15:0] exp);
		mode_in = m;
		byte1_in = b1;
		byte2_in = b2;
		take_in = 1'b1;
		step(1);
		chk("address", {10'h0, ea_out}, {10'h0, exp});
		take_in = 1'b0;
	endtask : agu

	// a reset source strikes in the middle of stacking
	task automatic t_abort(input int src);
		fire_trap();
		step(2);
		por_in = (src == 0);
		wdog_rst_in = (src == 1);
		ext_rst_n_in = (src != 2);
		src_done_in = 1'b0;
		step(1);
		if (src != 2) begin
			chk("bus on abort", {25'h0, bus_out.valid}, 26'h0);
		end
		step(2);
		chk("abort", {25'h0, abort_out}, 26'h1);
		chk("bus after abort", {25'h0, bus_out.valid}, 26'h0);
		por_in = 1'b0;
		wdog_rst_in = 1'b0;
		ext_rst_n_in = 1'b1;
		t_reset_walk();
		$display("test abort done");
	endtask : t_abort

	initial begin
		step(3);
		rst_in = 1'b0;
		t_reset_walk();
		t_trap_entry();
		t_irq_masked();
		agu(crs_pkg::CRS_AM_REL, 8'hF0, 8'h00, pc_out + 16'hFFF0);
		agu(crs_pkg::CRS_AM_IMM, 8'hAB, 8'hCD, 16'hABCD);
		agu(crs_pkg::CRS_AM_DIR, 8'h7E, 8'h99, 16'h007E);
		agu(crs_pkg::CRS_AM_SP2, 8'h12, 8'h34, 16'h00FA + 16'h1234);
		$display("test address_modes done");
		for (int s = 0; s < 3; s++) begin
			t_abort(s);
		end
		report_and_stop();
	end
endmodule : tb_cpu_reset_irq_sequencer_agu
